// ---- core/msc_pkg.sv ----
// constants and carrier types of the miscellaneous control register bank
package msc_pkg;
	// ----------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_RSVD_F0 = 8'hf0;
	localparam logic [7:0] IDX_RSVD_F1 = 8'hf1;
	localparam logic [7:0] IDX_CPU_MODE = 8'hf2;
	localparam logic [7:0] IDX_TAG_TYPE = 8'hf3;
	localparam logic [7:0] IDX_FILT_LO = 8'hf4;
	localparam logic [7:0] IDX_FILT_HI = 8'hf5;
	localparam logic [7:0] IDX_RSVD_F6 = 8'hf6;
	localparam logic [7:0] IDX_IRQ_MASK = 8'hf7;
	localparam logic [7:0] IDX_IRQ_STAT = 8'hf8;
	localparam logic [7:0] IDX_GIGA_DLY = 8'hf9;
	localparam logic [7:0] IDX_FAST_DLY = 8'hfa;
	localparam logic [7:0] IDX_EE_CMD = 8'hfb;
	localparam logic [7:0] IDX_EE_DATA = 8'hfc;
	localparam logic [7:0] IDX_SERDES_A = 8'hfd;
	localparam logic [7:0] IDX_SERDES_B = 8'hfe;
	localparam logic [7:0] IDX_PCS = 8'hff;
	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [4:0] RST_F0 = 5'h00;
	localparam logic [15:0] RST_F1 = 16'h001f;
	localparam logic [15:0] RST_CPU_MODE = 16'h0000;
	localparam logic [15:0] RST_TAG_TYPE = 16'h9126;
	localparam logic [15:0] RST_FILT = 16'h0000;
	localparam logic [8:0] RST_F6 = 9'h000;
	localparam logic [15:0] RST_IRQ_MASK = 16'h0002;
	localparam logic [7:0] RST_IRQ_STAT = 8'h02;
	localparam logic [15:0] RST_GIGA_DLY = 16'h1eba;
	localparam logic [15:0] RST_FAST_DLY = 16'h4100;
	localparam logic [15:0] RST_EE_CMD = 16'h0000;
	localparam logic [7:0] RST_EE_DATA = 8'h00;
	localparam logic [15:0] RST_SERDES = 16'hbe02;
	localparam logic [15:0] RST_PCS = 16'h3681;
	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int CPU_PORT_EN_BIT = 0;
	localparam int CPU_TAG_EN_BIT = 1;
	localparam int CPU_REV_MII_BIT = 2;
	localparam int CPU_CLK50_BIT = 3;
	localparam int MASK_POL_BIT = 15;
	localparam int ST_PHY_CMD = 0;
	localparam int ST_LINK = 1;
	localparam int ST_EE_DONE = 3;
	localparam int ST_PAGE0 = 4;
	localparam int ST_MODE0 = 6;
	localparam int EE_WRITE_BIT = 14;
	localparam int EE_DONE_BIT = 13;
	localparam int EE_GO_BIT = 15;
	localparam int PCS_SD_POL_BIT = 8;
	localparam logic [7:0] STAT_VALID = 8'hfb;
	localparam logic [7:0] PCS_COMBO = 8'h81;
	localparam logic [7:0] PCS_COPPER = 8'h01;
	// ----------------------------------------------------------------
	// clock output divider: 200 MHz core clock
	// ----------------------------------------------------------------
	localparam int CLK_MHZ = 200;
	localparam int CLKO_SLOW_MHZ = 25;
	localparam int CLKO_FAST_MHZ = 50;
	localparam int SLOW_HALF = CLK_MHZ / CLKO_SLOW_MHZ / 2;
	localparam int FAST_HALF = CLK_MHZ / CLKO_FAST_MHZ / 2;

	typedef struct packed {
		logic [1:0] rx_dly;
		logic rx_inv;
		logic [1:0] tx_dly;
		logic tx_inv;
		logic mii_sel;
		logic [1:0] pcs_rx_dly;
		logic pcs_rx_inv;
	} msc_giga_s;

	typedef struct packed {
		logic cpu_port_en;
		logic special_tag_en;
		logic [15:0] tag_type;
		logic rev_mii;
		logic combo_auto;
		logic copper_only;
		logic [1:0] giga_drive;
		logic [15:0] fast_dly;
		logic [15:0] serdes_a;
		logic [15:0] serdes_b;
		msc_giga_s giga_one;
		msc_giga_s giga_two;
	} msc_cfg_s;

	typedef struct packed {
		logic req;
		logic write;
		logic [2:0] dev_addr;
		logic [7:0] byte_addr;
		logic [7:0] wdata;
	} msc_ee_req_s;

	typedef enum logic {EE_IDLE, EE_BUSY} msc_ee_state_e;
endpackage

// ---- core/msc_regs.sv ----
// miscellaneous control register bank with avalon-mm slave and eeprom command
`timescale 1ns/1ps
//
// Functional notes
// R1: port 26 is cpu port when bit0 set
// R2: special tag enable inserts source port tag
// R3: tag type register, reset 9126
// R4: bit2 selects mii or reverse mii
// R5: bit3 selects 25 or 50 mhz out
// R6: ports 0-15 filter, gated by global enable
// R7: ports 16-26 filter, same global enable
// R8: mask bit one suppresses event
// R9: mask bit15 sets interrupt pin polarity
// R10: interrupt held until status register read
// R11: phy, link, eeprom done set status bits
// R12: fiber next page sets bits 4/5
// R13: copper/fiber mode change sets bits 6/7
// R14: rgmii rx/tx clock delay codes
// R15: rgmii clock reverse bits
// R16: bits 14/15 pick rgmii or mii
// R17: single byte eeprom read or write
// R18: go bit starts, clears; done bit set
// R19: write data from, read data into register
// R20: software keeps serdes registers at be02
// R21: pcs low byte picks combo or copper
// R22: signal detect polarity, pcs clock delays
// R23: event set wins over read clear
// R24: interrupt is or of unmasked bits
module msc_regs
	import msc_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [9:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic l4_filter_global_en,
	input wire logic ev_phy_cmd_done,
	input wire logic ev_link_change,
	input wire logic [1:0] ev_fiber_page,
	input wire logic [1:0] ev_mode_change,
	input wire logic [1:0] fiber_signal_detect,
	input wire logic ee_done,
	input wire logic [7:0] ee_rdata,
	output msc_ee_req_s ee_req,
	output msc_cfg_s cfg,
	output logic [26:0] l4_filter_en,
	output logic [1:0] fiber_sd_active,
	output logic clk_out,
	output logic irq_pin
);
	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	logic [4:0] rsvd_f0_ff;
	logic [15:0] rsvd_f1_ff;
	logic [15:0] cpu_port_mode_ff;
	logic [15:0] cpu_tag_type_ff;
	logic [15:0] filt_lo_ff;
	logic [15:0] filt_hi_ff;
	logic [8:0] rsvd_f6_ff;
	logic [15:0] irq_mask_ff;
	logic [7:0] irq_stat_ff;
	logic [15:0] giga_dly_ff;
	logic [15:0] fast_dly_ff;
	logic [15:0] ee_cmd_ff;
	logic [7:0] ee_data_ff;
	logic [15:0] serdes_a_ff;
	logic [15:0] serdes_b_ff;
	logic [15:0] pcs_ff;
	logic wait_ff;
	logic [31:0] rdata_ff;
	logic [26:0] filt_en_ff;
	logic irq_ff;
	logic [2:0] div_ff;
	logic clk_out_ff;
	logic [1:0] sd_meta_ff;
	logic [1:0] sd_sync_ff;
	logic [1:0] sd_act_ff;
	msc_ee_state_e ee_state_ff;
	logic combo_ff;
	logic copper_ff;

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	// one wait cycle on every access; the read data is latched in that
	// cycle so it stands at the completing edge
	wire [7:0] idx = avs_address[9:2];
	wire req_any = avs_read | avs_write;
	wire accept = req_any & ~wait_ff;
	wire wr_acc = avs_write & ~wait_ff;
	wire rd_acc = avs_read & ~wait_ff;
	wire [1:0] be = avs_byteenable[1:0];
	wire [15:0] wd = avs_writedata[15:0];

	function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] d,
		input logic [1:0] b);
		merge = {b[1] ? d[15:8] : old[15:8], b[0] ? d[7:0] : old[7:0]};
	endfunction

	wire wr_f0 = wr_acc & (idx == IDX_RSVD_F0);
	wire wr_f1 = wr_acc & (idx == IDX_RSVD_F1);
	wire wr_cpu = wr_acc & (idx == IDX_CPU_MODE);
	wire wr_tag = wr_acc & (idx == IDX_TAG_TYPE);
	wire wr_flo = wr_acc & (idx == IDX_FILT_LO);
	wire wr_fhi = wr_acc & (idx == IDX_FILT_HI);
	wire wr_f6 = wr_acc & (idx == IDX_RSVD_F6);
	wire wr_mask = wr_acc & (idx == IDX_IRQ_MASK);
	wire wr_stat = wr_acc & (idx == IDX_IRQ_STAT);
	wire wr_gdly = wr_acc & (idx == IDX_GIGA_DLY);
	wire wr_fdly = wr_acc & (idx == IDX_FAST_DLY);
	wire wr_ecmd = wr_acc & (idx == IDX_EE_CMD);
	wire wr_edat = wr_acc & (idx == IDX_EE_DATA);
	wire wr_sda = wr_acc & (idx == IDX_SERDES_A);
	wire wr_sdb = wr_acc & (idx == IDX_SERDES_B);
	wire wr_pcs = wr_acc & (idx == IDX_PCS);
	wire rd_stat = rd_acc & (idx == IDX_IRQ_STAT);
	wire rd_f0 = rd_acc & (idx == IDX_RSVD_F0);

	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	// mask register is write only and reads as zero
	logic [15:0] rmux;
	always_comb begin
		rmux = 16'h0000;
		unique case (idx)
			IDX_RSVD_F0: rmux = {11'h000, rsvd_f0_ff};
			IDX_RSVD_F1: rmux = rsvd_f1_ff;
			IDX_CPU_MODE: rmux = cpu_port_mode_ff;
			IDX_TAG_TYPE: rmux = cpu_tag_type_ff;
			IDX_FILT_LO: rmux = filt_lo_ff;
			IDX_FILT_HI: rmux = filt_hi_ff;
			IDX_RSVD_F6: rmux = {7'h00, rsvd_f6_ff};
			IDX_IRQ_STAT: rmux = {8'h00, irq_stat_ff};
			IDX_GIGA_DLY: rmux = giga_dly_ff;
			IDX_FAST_DLY: rmux = fast_dly_ff;
			IDX_EE_CMD: rmux = ee_cmd_ff;
			IDX_EE_DATA: rmux = {8'h00, ee_data_ff};
			IDX_SERDES_A: rmux = serdes_a_ff;
			IDX_SERDES_B: rmux = serdes_b_ff;
			IDX_PCS: rmux = pcs_ff;
			default: rmux = 16'h0000;
		endcase
	end

	wire [31:0] nxt_rdata = (avs_read & wait_ff) ? {16'h0000, rmux} : rdata_ff;
	wire nxt_wait = ~(req_any & wait_ff);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wait_ff <= 1'b1;
			rdata_ff <= 32'h00000000;
		end else begin
			wait_ff <= nxt_wait;
			rdata_ff <= nxt_rdata;
		end
	end

	// ----------------------------------------------------------------
	// plain registers: read/write, except the mask register which is write only
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rsvd_f1_ff <= RST_F1;
			cpu_port_mode_ff <= RST_CPU_MODE;
			cpu_tag_type_ff <= RST_TAG_TYPE;	// [R3]
			filt_lo_ff <= RST_FILT;
			filt_hi_ff <= RST_FILT;
			rsvd_f6_ff <= RST_F6;
			irq_mask_ff <= RST_IRQ_MASK;
			giga_dly_ff <= RST_GIGA_DLY;
			fast_dly_ff <= RST_FAST_DLY;
			serdes_a_ff <= RST_SERDES;	// [R20]
			serdes_b_ff <= RST_SERDES;	// [R20]
			pcs_ff <= RST_PCS;
		end else begin
			if (wr_f1) rsvd_f1_ff <= merge(rsvd_f1_ff, wd, be);
			if (wr_cpu) cpu_port_mode_ff <= merge(cpu_port_mode_ff, wd, be);
			if (wr_tag) cpu_tag_type_ff <= merge(cpu_tag_type_ff, wd, be);	// [R3]
			if (wr_flo) filt_lo_ff <= merge(filt_lo_ff, wd, be);
			if (wr_fhi) filt_hi_ff <= merge(filt_hi_ff, wd, be);
			if (wr_f6) rsvd_f6_ff <= 9'(merge({7'h00, rsvd_f6_ff}, wd, be));
			if (wr_mask) irq_mask_ff <= merge(irq_mask_ff, wd, be);
			if (wr_gdly) giga_dly_ff <= merge(giga_dly_ff, wd, be);
			if (wr_fdly) fast_dly_ff <= merge(fast_dly_ff, wd, be);
			if (wr_sda) serdes_a_ff <= merge(serdes_a_ff, wd, be);
			if (wr_sdb) serdes_b_ff <= merge(serdes_b_ff, wd, be);
			if (wr_pcs) pcs_ff <= merge(pcs_ff, wd, be);
		end
	end

	// self clearing reserved register: cleared by the read that returns it
	wire [4:0] nxt_rsvd_f0 = wr_f0 ? 5'(merge({11'h000, rsvd_f0_ff}, wd, be)) :
		(rd_f0 ? 5'h00 : rsvd_f0_ff);

	always_ff @(posedge clk) begin
		if (sys_rst) rsvd_f0_ff <= RST_F0;
		else rsvd_f0_ff <= nxt_rsvd_f0;
	end

	// ----------------------------------------------------------------
	// eeprom command engine
	// ----------------------------------------------------------------
	// a command written while one is running is dropped: the engine
	// reads address and direction live from the command register, so rewriting would be unsafe
	wire ee_start = wr_ecmd & be[1] & wd[EE_GO_BIT] & (ee_state_ff == EE_IDLE);	// [R18]
	wire ee_finish = (ee_state_ff == EE_BUSY) & ee_done;
	wire ee_cmd_rw = wr_ecmd & (ee_state_ff == EE_IDLE);
	// data byte frozen while busy too: the request shows it to the engine
	wire ee_data_wr = wr_edat & be[0] & (ee_state_ff == EE_IDLE);	// [R19]

	msc_ee_state_e nxt_ee_state;
	logic [15:0] nxt_ee_cmd;
	logic [7:0] nxt_ee_data;
	always_comb begin
		nxt_ee_state = ee_state_ff;
		nxt_ee_cmd = ee_cmd_ff;
		nxt_ee_data = ee_data_wr ? wd[7:0] : ee_data_ff;	// [R19]
		unique case (ee_state_ff)
			EE_IDLE: begin
				if (ee_cmd_rw) begin
					nxt_ee_cmd = merge(ee_cmd_ff, wd, be);
					nxt_ee_cmd[EE_DONE_BIT] = 1'b0;
				end
				if (ee_start) nxt_ee_state = EE_BUSY;	// [R17]
			end
			EE_BUSY: begin
				if (ee_finish) begin
					nxt_ee_state = EE_IDLE;
					nxt_ee_cmd[EE_GO_BIT] = 1'b0;	// [R18]
					nxt_ee_cmd[EE_DONE_BIT] = 1'b1;	// [R18]
					if (!ee_cmd_ff[EE_WRITE_BIT]) nxt_ee_data = ee_rdata;	// [R19]
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ee_state_ff <= EE_IDLE;
			ee_cmd_ff <= RST_EE_CMD;
			ee_data_ff <= RST_EE_DATA;
		end else begin
			ee_state_ff <= nxt_ee_state;
			ee_cmd_ff <= nxt_ee_cmd;
			ee_data_ff <= nxt_ee_data;
		end
	end

	// request is a level held from start until the engine reports done
	assign ee_req.req = ee_state_ff == EE_BUSY;	// [R17]
	assign ee_req.write = ee_cmd_ff[EE_WRITE_BIT];	// [R17]
	assign ee_req.dev_addr = ee_cmd_ff[10:8];	// [R17]
	assign ee_req.byte_addr = ee_cmd_ff[7:0];	// [R17]
	assign ee_req.wdata = ee_data_ff;	// [R19]

	// ----------------------------------------------------------------
	// event status and interrupt
	// ----------------------------------------------------------------
	logic [7:0] ev_set;
	always_comb begin
		ev_set = 8'h00;
		ev_set[ST_PHY_CMD] = ev_phy_cmd_done;	// [R11]
		ev_set[ST_LINK] = ev_link_change;	// [R11]
		ev_set[ST_EE_DONE] = ee_finish;	// [R11]
		ev_set[ST_PAGE0 +: 2] = ev_fiber_page;	// [R12]
		ev_set[ST_MODE0 +: 2] = ev_mode_change;	// [R13]
	end

	// a status write on lane 0 replaces the whole status byte; new events still set bits
	wire [7:0] stat_keep = rd_stat ? 8'h00 : irq_stat_ff;	// [R11] [R12] [R13]
	wire [7:0] stat_wr = (wr_stat & be[0]) ? wd[7:0] : stat_keep;
	wire [7:0] nxt_irq_stat = (stat_wr | ev_set) & STAT_VALID;	// [R23]
	wire irq_any = |(irq_stat_ff & ~irq_mask_ff[7:0] & STAT_VALID);	// [R8] [R24]
	// level follows status, so it holds until the status read clears it
	wire nxt_irq = irq_mask_ff[MASK_POL_BIT] ? irq_any : ~irq_any;	// [R9] [R10]

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			irq_stat_ff <= RST_IRQ_STAT;
			irq_ff <= 1'b1;
		end else begin
			irq_stat_ff <= nxt_irq_stat;
			irq_ff <= nxt_irq;
		end
	end

	// ----------------------------------------------------------------
	// filter enables, clock output, signal detect
	// ----------------------------------------------------------------
	wire [26:0] nxt_filt_en = l4_filter_global_en ?
		{filt_hi_ff[10:0], filt_lo_ff} : 27'h0000000;	// [R6] [R7]

	// divider counts half periods; a rate switch applies at once, wrapping on the next edge if the count is past the new limit
	wire [2:0] half_cnt = cpu_port_mode_ff[CPU_CLK50_BIT] ?
		3'(FAST_HALF - 1) : 3'(SLOW_HALF - 1);	// [R5]
	wire div_wrap = div_ff >= half_cnt;
	wire [2:0] nxt_div = div_wrap ? 3'h0 : div_ff + 3'h1;
	wire nxt_clk_out = div_wrap ? ~clk_out_ff : clk_out_ff;	// [R5]

	wire [1:0] nxt_sd_act = pcs_ff[PCS_SD_POL_BIT] ? sd_sync_ff : ~sd_sync_ff;	// [R22]

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			filt_en_ff <= 27'h0000000;
			div_ff <= 3'h0;
			clk_out_ff <= 1'b0;
			sd_meta_ff <= 2'h0;
			sd_sync_ff <= 2'h0;
			sd_act_ff <= 2'h0;
		end else begin
			filt_en_ff <= nxt_filt_en;
			div_ff <= nxt_div;
			clk_out_ff <= nxt_clk_out;
			sd_meta_ff <= fiber_signal_detect;
			sd_sync_ff <= sd_meta_ff;
			sd_act_ff <= nxt_sd_act;
		end
	end

	// ----------------------------------------------------------------
	// pcs mode decode
	// ----------------------------------------------------------------
	// decoded from the next value so the registered flags move with the
	// register itself, with no extra cycle of lag
	wire [15:0] nxt_pcs = wr_pcs ? merge(pcs_ff, wd, be) : pcs_ff;
	wire nxt_combo = nxt_pcs[7:0] == PCS_COMBO;	// [R21]
	wire nxt_copper = nxt_pcs[7:0] == PCS_COPPER;	// [R21]

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			combo_ff <= RST_PCS[7:0] == PCS_COMBO;
			copper_ff <= RST_PCS[7:0] == PCS_COPPER;
		end else begin
			combo_ff <= nxt_combo;
			copper_ff <= nxt_copper;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign avs_waitrequest = wait_ff;
	assign avs_readdata = rdata_ff;
	assign l4_filter_en = filt_en_ff;
	assign clk_out = clk_out_ff;
	assign irq_pin = irq_ff;
	assign fiber_sd_active = sd_act_ff;

	assign cfg.cpu_port_en = cpu_port_mode_ff[CPU_PORT_EN_BIT];	// [R1]
	assign cfg.special_tag_en = cpu_port_mode_ff[CPU_TAG_EN_BIT];	// [R2]
	assign cfg.tag_type = cpu_tag_type_ff;	// [R2] [R3]
	assign cfg.rev_mii = cpu_port_mode_ff[CPU_REV_MII_BIT];	// [R4]
	assign cfg.combo_auto = combo_ff;	// [R21]
	assign cfg.copper_only = copper_ff;	// [R21]
	assign cfg.giga_drive = giga_dly_ff[13:12];
	assign cfg.fast_dly = fast_dly_ff;
	assign cfg.serdes_a = serdes_a_ff;
	assign cfg.serdes_b = serdes_b_ff;
	assign cfg.giga_one.rx_dly = giga_dly_ff[1:0];	// [R14]
	assign cfg.giga_one.rx_inv = giga_dly_ff[2];	// [R15]
	assign cfg.giga_one.tx_dly = giga_dly_ff[4:3];	// [R14]
	assign cfg.giga_one.tx_inv = giga_dly_ff[5];	// [R15]
	assign cfg.giga_one.mii_sel = giga_dly_ff[14];	// [R16]
	assign cfg.giga_one.pcs_rx_dly = pcs_ff[10:9];	// [R22]
	assign cfg.giga_one.pcs_rx_inv = pcs_ff[11];	// [R22]
	assign cfg.giga_two.rx_dly = giga_dly_ff[7:6];	// [R14]
	assign cfg.giga_two.rx_inv = giga_dly_ff[8];	// [R15]
	assign cfg.giga_two.tx_dly = giga_dly_ff[10:9];	// [R14]
	assign cfg.giga_two.tx_inv = giga_dly_ff[11];	// [R15]
	assign cfg.giga_two.mii_sel = giga_dly_ff[15];	// [R16]
	assign cfg.giga_two.pcs_rx_dly = pcs_ff[13:12];	// [R22]
	assign cfg.giga_two.pcs_rx_inv = pcs_ff[14];	// [R22]
endmodule // msc_regs

// ---- dv/msc_regs_asserts.sv ----
// property checker for the miscellaneous control register bank
`timescale 1ns/1ps
module msc_regs_asserts
	import msc_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [9:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic avs_waitrequest,
	input wire logic l4_filter_global_en,
	input wire logic ee_done,
	input wire msc_ee_req_s ee_req,
	input wire msc_cfg_s cfg,
	input wire logic [26:0] l4_filter_en
);
	// ----------------------------------------------------------------
	// helpers: full-word writes only, partial lanes leave old bytes
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	logic [15:0] wd_ff;
	wire [7:0] idx = avs_address[9:2];
	wire wr_both = avs_write && !avs_waitrequest && avs_byteenable[1:0] == 2'h3;
	always_ff @(posedge clk) wd_ff <= avs_writedata[15:0];

	bus_wait_a: assert property (
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus answer not after one wait cycle");
	filt_gate_a: assert property (
		!l4_filter_global_en |=> l4_filter_en == 27'h0)
		else $error("filter enables on without global enable");
	tag_load_a: assert property (
		wr_both && idx == IDX_TAG_TYPE |=> cfg.tag_type == wd_ff)
		else $error("tag type not loaded");
	cpu_mode_a: assert property (
		wr_both && idx == IDX_CPU_MODE |=>
		{cfg.rev_mii, cfg.special_tag_en, cfg.cpu_port_en} == wd_ff[2:0])
		else $error("cpu mode bits not applied");
	pcs_mode_a: assert property (
		wr_both && idx == IDX_PCS |=> cfg.combo_auto == (wd_ff[7:0] == PCS_COMBO)
		&& cfg.copper_only == (wd_ff[7:0] == PCS_COPPER))
		else $error("pcs mode decode wrong");
	giga_dly_a: assert property (
		wr_both && idx == IDX_GIGA_DLY |=> cfg.giga_two[9:3] ==
		{wd_ff[7:6], wd_ff[8], wd_ff[10:9], wd_ff[11], wd_ff[15]})
		else $error("second giga port delay fields wrong");
	ee_start_a: assert property (
		wr_both && idx == IDX_EE_CMD && avs_writedata[15] && !ee_req.req |=> ee_req.req
		&& ee_req.byte_addr == wd_ff[7:0] && ee_req.dev_addr == wd_ff[10:8]
		&& ee_req.write == wd_ff[14])
		else $error("eeprom command not started");
	ee_hold_a: assert property (
		ee_req.req && !ee_done |=> $stable(ee_req))
		else $error("eeprom request moved before done");
	ee_end_a: assert property (
		ee_req.req && ee_done |=> !ee_req.req)
		else $error("eeprom request not ended by done");
endmodule // msc_regs_asserts

bind msc_regs msc_regs_asserts u_chk (.clk, .sys_rst, .avs_address, .avs_read, .avs_write,
	.avs_writedata, .avs_byteenable, .avs_waitrequest, .l4_filter_global_en, .ee_done,
	.ee_req, .cfg, .l4_filter_en);

// ---- dv/msc_ee_model.sv ----
// serial eeprom engine stand-in on the far side of the command port
`timescale 1ns/1ps
module msc_ee_model
	import msc_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic slow,
	input wire msc_ee_req_s ee_req,
	output logic ee_done,
	output logic [7:0] ee_rdata
);
	// ----------------------------------------------------------------
	// byte store; read byte is valid only in the done cycle
	// ----------------------------------------------------------------
	logic [7:0] mem_ff [2048];
	int cnt_ff;
	logic seen_ff;
	wire [10:0] loc = {ee_req.dev_addr, ee_req.byte_addr};
	initial for (int i = 0; i < 2048; i++) mem_ff[i] = 8'(i);
	always @(posedge clk) begin
		ee_done <= 1'h0;
		ee_rdata <= ~ee_rdata;
		if (sys_rst) begin
			cnt_ff <= 0;
			seen_ff <= 1'h0;
			ee_rdata <= 8'h00;
		end else if (ee_req.req && !seen_ff) begin
			cnt_ff <= cnt_ff + 1;
			if (cnt_ff == (slow ? 40 : 16)) begin
				ee_done <= 1'h1;
				seen_ff <= 1'h1;
				cnt_ff <= 0;
				if (ee_req.write) mem_ff[loc] <= ee_req.wdata;
				else ee_rdata <= mem_ff[loc];
			end
		end else if (!ee_req.req) seen_ff <= 1'h0;
	end
endmodule // msc_ee_model

// ---- dv/tb_top.sv ----
// self-checking bench for the miscellaneous control register bank
`timescale 1ns/1ps
module tb_top
	import msc_pkg::*;
;
	logic clk = 1'h0;
	logic sys_rst = 1'h1;
	logic [9:0] avs_address = 10'h000;
	logic avs_read = 1'h0;
	logic avs_write = 1'h0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'h3;
	logic l4_filter_global_en = 1'h0;
	logic ev_phy_cmd_done = 1'h0;
	logic ev_link_change = 1'h0;
	logic [1:0] ev_fiber_page = 2'h0;
	logic [1:0] ev_mode_change = 2'h0;
	logic [1:0] fiber_signal_detect = 2'h0;
	logic ee_slow = 1'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic ee_done;
	logic [7:0] ee_rdata;
	msc_ee_req_s ee_req;
	msc_cfg_s cfg;
	logic [26:0] l4_filter_en;
	logic [1:0] fiber_sd_active;
	logic clk_out;
	logic irq_pin;
	int n_errors = 0;
	int total_checks = 0;
	logic [31:0] q;

	msc_regs DUT (.clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable, .avs_readdata, .avs_waitrequest, .l4_filter_global_en,
		.ev_phy_cmd_done, .ev_link_change, .ev_fiber_page, .ev_mode_change,
		.fiber_signal_detect, .ee_done, .ee_rdata, .ee_req, .cfg, .l4_filter_en,
		.fiber_sd_active, .clk_out, .irq_pin);
	msc_ee_model u_ee (.clk, .sys_rst, .slow(ee_slow), .ee_req, .ee_done, .ee_rdata);

	always #2.5 clk = ~clk;
	// ----------------------------------------------------------------
	// bus and compare helpers
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			n_errors++;
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	// waitrequest is read before the edge's own updates land; a hang is
	// left to the watchdog
	task automatic ack();
		do @(posedge clk);
		while (avs_waitrequest !== 1'h0);
	endtask
	task automatic wr(input logic [7:0] idx, input logic [15:0] d);
		@(posedge clk);
		avs_address <= {idx, 2'h0};
		avs_writedata <= {16'h0, d};
		avs_write <= 1'h1;
		ack();
		avs_write <= 1'h0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] idx);
		@(posedge clk);
		avs_address <= {idx, 2'h0};
		avs_read <= 1'h1;
		ack();
		q = avs_readdata;
		avs_read <= 1'h0;
	endtask
	task automatic rc(input logic [7:0] idx, input logic [15:0] e);
		rd(idx);
		chk(q, {16'h0, e});
	endtask
	task automatic ev(input logic [5:0] v);
		@(posedge clk);
		{ev_mode_change, ev_fiber_page, ev_link_change, ev_phy_cmd_done} <= v;
		@(posedge clk);
		{ev_mode_change, ev_fiber_page, ev_link_change, ev_phy_cmd_done} <= 6'h0;
	endtask
	task automatic ee_wait();
		int n;
		n = 0;
		while (ee_req.req !== 1'h0 && n < 200) begin
			@(posedge clk);
			n++;
		end
	endtask
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		logic [15:0] tab [16] = '{16'h0, 16'h1f, 16'h0, 16'h9126, 16'h0, 16'h0, 16'h0, 16'h0,
			16'h2, 16'h1eba, 16'h4100, 16'h0, 16'h0, 16'hbe02, 16'hbe02, 16'h3681};
		chk(32'(irq_pin), 32'h1);
		for (int i = 0; i < 16; i++) rc(8'hf0 + i[7:0], tab[i]);
		wr(8'h00, 16'hffff);
		rc(8'h00, 16'h0);
		$display("reset test done");
	endtask
	task automatic t_cpu();
		logic c;
		int n;
		wr(IDX_CPU_MODE, 16'h0007);
		chk(32'({cfg.rev_mii, cfg.special_tag_en, cfg.cpu_port_en}), 32'h7);
		wr(IDX_TAG_TYPE, 16'habcd);
		chk(32'(cfg.tag_type), 32'habcd);
		for (int m = 0; m < 2; m++) begin
			wr(IDX_CPU_MODE, {12'h0, m[0], 3'h2});
			cyc(12);
			c = clk_out;
			while (clk_out === c) @(posedge clk);
			c = clk_out;
			n = 0;
			while (clk_out === c && n < 20) begin
				@(posedge clk);
				n++;
			end
			chk(32'(n), 32'(m ? FAST_HALF : SLOW_HALF));
		end
		$display("cpu mode test done");
	endtask
	task automatic t_filter();
		wr(IDX_FILT_LO, 16'ha5c3);
		wr(IDX_FILT_HI, 16'hf7ff);
		l4_filter_global_en <= 1'h1;
		cyc(3);
		chk(32'(l4_filter_en), {5'h0, 11'h7ff, 16'ha5c3});
		l4_filter_global_en <= 1'h0;
		cyc(3);
		chk(32'(l4_filter_en), 32'h0);
		$display("filter test done");
	endtask
	task automatic t_irq();
		wr(IDX_IRQ_MASK, 16'h0000);
		ev(6'h01);
		cyc(6);
		chk(32'(irq_pin), 32'h0);
		rc(IDX_IRQ_STAT, 16'h0001);
		cyc(3);
		chk(32'(irq_pin), 32'h1);
		wr(IDX_IRQ_MASK, 16'h8001);
		ev(6'h01);
		cyc(3);
		chk(32'(irq_pin), 32'h0);
		ev(6'h3e);
		cyc(3);
		chk(32'(irq_pin), 32'h1);
		rc(IDX_IRQ_STAT, 16'h00f3);
		fork
			rd(IDX_IRQ_STAT);
			begin
				cyc(2);
				ev_link_change <= 1'h1;
				cyc(1);
				ev_link_change <= 1'h0;
			end
		join
		chk(q, 32'h0);
		rc(IDX_IRQ_STAT, 16'h0002);
		wr(IDX_IRQ_MASK, 16'h0002);
		$display("interrupt test done");
	endtask
	task automatic t_eeprom();
		wr(IDX_EE_DATA, 16'h005a);
		wr(IDX_EE_CMD, 16'hc53c);
		chk(32'({ee_req.write, ee_req.dev_addr, ee_req.byte_addr, ee_req.wdata}), 32'hd3c5a);
		rc(IDX_EE_CMD, 16'hc53c);
		wr(IDX_EE_CMD, 16'h8011);
		ee_wait();
		rc(IDX_EE_CMD, 16'h653c);
		rc(IDX_IRQ_STAT, 16'h0008);
		ee_slow <= 1'h1;
		wr(IDX_EE_DATA, 16'h0000);
		wr(IDX_EE_CMD, 16'h853c);
		ee_wait();
		rc(IDX_EE_DATA, 16'h005a);
		rc(IDX_EE_CMD, 16'h253c);
		$display("eeprom test done");
	endtask
	task automatic t_phy();
		wr(IDX_PCS, 16'h0001);
		chk(32'({cfg.combo_auto, cfg.copper_only}), 32'h1);
		wr(IDX_PCS, 16'h3681);
		chk(32'({cfg.combo_auto, cfg.copper_only}), 32'h2);
		chk(32'({cfg.giga_one[2:0], cfg.giga_two[2:0]}), 32'h36);
		fiber_signal_detect <= 2'h1;
		cyc(5);
		chk(32'(fiber_sd_active), 32'h2);
		wr(IDX_PCS, 16'h3781);
		cyc(2);
		chk(32'(fiber_sd_active), 32'h1);
		wr(IDX_GIGA_DLY, 16'h4ac6);
		chk(32'({cfg.giga_one[9:3], cfg.giga_two[9:3]}), {18'h0, 7'h51, 7'h66});
		avs_byteenable <= 4'h1;
		wr(IDX_SERDES_A, 16'h1234);
		avs_byteenable <= 4'h3;
		rc(IDX_SERDES_A, 16'hbe34);
		wr(IDX_SERDES_A, 16'hbe02);
		wr(IDX_SERDES_B, 16'hbe02);
		$display("phy setting test done");
	endtask
	task automatic end_of_test();
		$display("checks=%0d errors=%0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	initial begin
		repeat (3) @(posedge clk);
		sys_rst <= 1'h0;
		t_reset();
		t_cpu();
		t_filter();
		t_irq();
		t_eeprom();
		t_phy();
		end_of_test();
	end
	// a few hundred cycles are expected; the 20000-cycle limit is far beyond that, so reaching it is a hang
	initial begin
		#100000;
		n_errors++;
		end_of_test();
	end
endmodule // tb_top
